// ### inc/nip_pkg.sv
// constants shared by the nested interrupt priority controller
package nip_pkg;
    // register byte offsets on the avalon slave
    localparam logic [5:0] ADDR_VPRIO0 = 6'h00;
    localparam logic [5:0] ADDR_VPRIO1 = 6'h04;
    localparam logic [5:0] ADDR_VPRIO2 = 6'h08;
    localparam logic [5:0] ADDR_VPRIO3 = 6'h0C;
    localparam logic [5:0] ADDR_SENSE = 6'h10;
    localparam logic [5:0] ADDR_PINSEL = 6'h14;
    localparam logic [5:0] ADDR_MODE = 6'h18;
    localparam logic [5:0] ADDR_STATUS = 6'h1C;
    localparam logic [5:0] ADDR_PEND = 6'h20;
    // field positions
    localparam int CC_HIGH_POS = 5;
    localparam int CC_LOW_POS = 3;
    localparam int STAT_HALT_POS = 0;
    localparam int STAT_HANDLER_POS = 1;
    localparam int MODE_NESTED_POS = 0;
    localparam int PAIRS_PER_REG = 4;
    localparam int NUM_PAIRS = 16;
    localparam int RO_PAIR_FIRST = 14;
    // priority codes, same encoding in condition code and vector registers
    localparam logic [1:0] CODE_L0 = 2'h2;
    localparam logic [1:0] CODE_L1 = 2'h1;
    localparam logic [1:0] CODE_L2 = 2'h0;
    localparam logic [1:0] CODE_L3 = 2'h3;
    localparam logic [7:0] VPRIO_RST = 8'hFF;
    localparam logic [1:0] CC_PRIO_RST = 2'h3;
    localparam logic MODE_RST = 1'h1;
    // external sensitivity per group
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    // vector numbers of the non-maskable sources, and the default wake mask
    localparam logic [3:0] VEC_TRAP = 4'hE;
    localparam logic [3:0] VEC_RESET = 4'hF;
    localparam logic [15:0] WAKE_MASK_DEF = 16'h041D;

    function automatic logic [1:0] code_to_level(input logic [1:0] c);
        case (c)
            CODE_L0: code_to_level = 2'h0;
            CODE_L1: code_to_level = 2'h1;
            CODE_L2: code_to_level = 2'h2;
            default: code_to_level = 2'h3;
        endcase
    endfunction
endpackage

// ### src/ext_irq_in.sv
// one external interrupt group: pin synchronisers, pin merge, edge latch
`timescale 1ns/1ps
module ext_irq_in import nip_pkg::*; #(
    parameter int PINS = 4
) (
    input wire logic clock, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [PINS-1:0] pin, // asynchronous pins
    input wire logic [PINS-1:0] sel, // pins taking part
    input wire logic [1:0] sense, // sensitivity code
    input wire logic ack, // vector entered
    output logic req_q // request to the controller
);
    logic [PINS-1:0] s1_q;
    logic [PINS-1:0] s2_q;
    logic [PINS-1:0] s3_q;
    logic [PINS-1:0] lvl_q;
    logic any_q;
    logic high_any;
    logic low_any;
    logic edge_hit;

    initial begin
        if (PINS < 1) $error("PINS must be at least 1");
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            // idle pins read high, so no false edge follows reset
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
            lvl_q <= '1;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < PINS; i++) begin
                if (s2_q[i] == s3_q[i]) lvl_q[i] <= s2_q[i];
            end
        end
    end

    // selected pins of the group are merged by or
    assign high_any = |(lvl_q & sel);
    assign low_any = |(~lvl_q & sel);

    always_ff @(posedge clock) begin
        if (rst) any_q <= 1'b0;
        else any_q <= high_any;
    end

    always_comb begin
        case (sense)
            SENSE_RISE: edge_hit = high_any & ~any_q;
            SENSE_FALL: edge_hit = ~high_any & any_q;
            SENSE_BOTH: edge_hit = high_any ^ any_q;
            default: edge_hit = 1'b0;
        endcase
    end

    // an edge is latched until entry; a new edge beats the ack
    always_ff @(posedge clock) begin
        if (rst) req_q <= 1'b0;
        else if (sense == SENSE_LOW) req_q <= low_any;
        else req_q <= edge_hit | (req_q & ~ack);
    end
endmodule

// ### src/prio_arbiter.sv
// two-step arbitration: software level first, then fixed vector order
`timescale 1ns/1ps
module prio_arbiter import nip_pkg::*; #(
    parameter int N = 13
) (
    input wire logic [N-1:0] req, // eligible pending vectors
    input wire logic [2*N-1:0] codes, // priority code per vector
    input wire logic [1:0] cur_level, // current running level
    output logic found, // some vector beats cur_level
    output logic [3:0] idx, // winning vector
    output logic [1:0] win_level // level of the winner
);
    logic [1:0] lv;

    initial begin
        if (N < 1 || N > 14) $error("N must be 1 to 14");
    end

    // descending scan with >= lets the lower index win a tie
    always_comb begin
        found = 1'b0;
        idx = 4'h0;
        win_level = 2'h0;
        lv = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            lv = code_to_level(codes[2*i +: 2]);
            if (req[i] && lv > cur_level && (!found || lv >= win_level)) begin
                found = 1'b1;
                idx = 4'(i);
                win_level = lv;
            end
        end
    end
endmodule

// ### src/nested_interrupt_priority.sv
// nested interrupt controller with avalon-mm register slave
//
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module nested_interrupt_priority import nip_pkg::*; #(
    parameter int NUM_VEC = 13,
    parameter int EXT_GROUPS = 3,
    parameter int EXT_VEC_BASE = 2,
    parameter int GRP_PINS = 4,
    parameter logic [15:0] WAKE_MASK = WAKE_MASK_DEF
) (
    input wire logic clock, // 250 MHz system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [5:0] address, // avalon byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [3:0] byteenable, // avalon byte enables
    input wire logic [31:0] writedata, // avalon write data
    output logic [31:0] readdata_q, // avalon read data
    output logic waitrequest_q, // avalon wait request
    input wire logic [EXT_GROUPS*GRP_PINS-1:0] ext_pin, // external pins
    input wire logic [NUM_VEC-1:0] periph_flag, // peripheral status flags
    input wire logic [NUM_VEC-1:0] periph_en, // peripheral enable bits
    input wire logic [NUM_VEC-1:0] periph_clr, // clear sequence pulse
    input wire logic instr_done, // core at instruction boundary
    input wire logic trap_exec, // trap instruction executed
    input wire logic rim_exec, // irq_enable_instr executed
    input wire logic sim_exec, // irq_disable_instr executed
    input wire logic halt_exec, // halt instruction executed
    input wire logic wfi_exec, // wait_irq_instr executed
    input wire logic irq_return_instr_exec, // irq_return_instr executed
    input wire logic [1:0] irq_return_instr_code, // priority bits popped by irq_return_instr
    input wire logic popcc_exec, // pop cc executed
    input wire logic [1:0] popcc_code, // priority bits popped by pop cc
    output logic irq_take_q, // one-cycle entry request to core
    output logic [3:0] irq_vec_q, // vector being entered
    output logic irq_stack_q, // core must stack pc, x, a, cc
    output logic prio_bit_high_q, // current priority, high bit
    output logic prio_bit_low_q, // current priority, low bit
    output logic halted_q // core held in halt
);
    typedef enum logic {RUN, HALT} run_state_t;

    localparam int SEL_W = EXT_GROUPS * GRP_PINS;

    run_state_t state_q;
    logic [NUM_PAIRS-1:0][1:0] prio_q;
    logic [2*EXT_GROUPS-1:0] sense_q;
    logic [SEL_W-1:0] pinsel_q;
    logic nested_q;
    logic [NUM_VEC-1:0] per_pend_q;
    logic reset_pend_q;
    logic trap_pend_q;
    logic [3:0] depth_q;
    logic [EXT_GROUPS-1:0] ext_req;
    logic [EXT_GROUPS-1:0] ext_ack;
    logic [NUM_VEC-1:0] pend;
    logic [NUM_VEC-1:0] elig;
    logic [2*NUM_VEC-1:0] codes;
    logic [1:0] cur_code;
    logic [1:0] cur_level;
    logic found;
    logic [3:0] win_idx;
    logic [1:0] win_level;
    logic cc_op;
    logic take_reset;
    logic take_trap;
    logic take_mask;
    logic acc;
    logic bus_wr;
    logic [31:0] rd_word;
    logic [31:0] wmask;

    initial begin
        if (NUM_VEC < 1 || NUM_VEC > 14) $error("NUM_VEC must be 1 to 14");
        if (EXT_VEC_BASE + EXT_GROUPS > NUM_VEC) $error("ext groups overflow");
        if (SEL_W > 32 || 2 * EXT_GROUPS > 32) $error("ext fields too wide");
    end

    function automatic logic [7:0] vprio_word(
        input logic [NUM_PAIRS-1:0][1:0] p, input int r);
        vprio_word = {p[4*r+3], p[4*r+2], p[4*r+1], p[4*r]};
    endfunction

    // ---- avalon slave: one wait cycle, then the answer ----
    assign acc = (read | write) & ~waitrequest_q;
    assign bus_wr = write & ~waitrequest_q;
    assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                    {8{byteenable[1]}}, {8{byteenable[0]}}};

    always_ff @(posedge clock) begin
        if (rst) waitrequest_q <= 1'b1;
        else if ((read | write) & waitrequest_q) waitrequest_q <= 1'b0;
        else waitrequest_q <= 1'b1;
    end

    assign cur_code = {prio_bit_high_q, prio_bit_low_q};

    always_comb begin
        rd_word = 32'h0000_0000;
        case (address)
            ADDR_VPRIO0: rd_word[7:0] = vprio_word(prio_q, 0);
            ADDR_VPRIO1: rd_word[7:0] = vprio_word(prio_q, 1);
            ADDR_VPRIO2: rd_word[7:0] = vprio_word(prio_q, 2);
            ADDR_VPRIO3: rd_word[7:0] = vprio_word(prio_q, 3);
            ADDR_SENSE: rd_word[2*EXT_GROUPS-1:0] = sense_q;
            ADDR_PINSEL: rd_word[SEL_W-1:0] = pinsel_q;
            ADDR_MODE: rd_word[MODE_NESTED_POS] = nested_q;
            ADDR_STATUS: begin
                rd_word[CC_HIGH_POS] = prio_bit_high_q;
                rd_word[CC_LOW_POS] = prio_bit_low_q;
                rd_word[STAT_HALT_POS] = halted_q;
                rd_word[STAT_HANDLER_POS] = (depth_q != 4'h0);
            end
            ADDR_PEND: rd_word[NUM_VEC-1:0] = pend;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) readdata_q <= 32'h0000_0000;
        else if (read & waitrequest_q) readdata_q <= rd_word;
    end

    // ---- vector priority pairs ----
    // pairs 14 and 15 always read as ones
    always_ff @(posedge clock) begin
        if (rst) begin
            prio_q <= {4{VPRIO_RST}};
        end else if (bus_wr && byteenable[0] && address[5:4] == 2'h0
                     && address[1:0] == 2'h0) begin
            for (int j = 0; j < PAIRS_PER_REG; j++) begin
                if (writedata[2*j +: 2] != CODE_L0
                    && 4 * int'(address[3:2]) + j < RO_PAIR_FIRST)
                    prio_q[4*address[3:2]+j] <= writedata[2*j +: 2];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sense_q <= '0;
            pinsel_q <= '0;
            nested_q <= MODE_RST;
        end else if (bus_wr) begin
            case (address)
                ADDR_SENSE: sense_q <= (writedata[2*EXT_GROUPS-1:0]
                    & wmask[2*EXT_GROUPS-1:0])
                    | (sense_q & ~wmask[2*EXT_GROUPS-1:0]);
                ADDR_PINSEL: pinsel_q <= (writedata[SEL_W-1:0]
                    & wmask[SEL_W-1:0]) | (pinsel_q & ~wmask[SEL_W-1:0]);
                ADDR_MODE: if (byteenable[0])
                    nested_q <= writedata[MODE_NESTED_POS];
                default: nested_q <= nested_q;
            endcase
        end
    end

    // ---- request sources ----
    genvar g;
    generate
        for (g = 0; g < EXT_GROUPS; g++) begin : ext_grp
            assign ext_ack[g] = irq_take_q
                && irq_vec_q == 4'(EXT_VEC_BASE + g);
            ext_irq_in #(.PINS(GRP_PINS)) u_ext (
                .clock(clock),
                .rst(rst),
                .pin(ext_pin[g*GRP_PINS +: GRP_PINS]),
                .sel(pinsel_q[g*GRP_PINS +: GRP_PINS]),
                .sense(sense_q[2*g +: 2]),
                .ack(ext_ack[g]),
                .req_q(ext_req[g])
            );
        end
    endgenerate

    // peripheral latch: set while flag and enable, dropped by the
    // clear sequence; a live flag wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (rst) per_pend_q <= '0;
        else per_pend_q <= (periph_flag & periph_en)
            | (per_pend_q & ~periph_clr);
    end

    always_comb begin
        pend = per_pend_q;
        for (int v = 0; v < NUM_VEC; v++) begin
            if (v >= EXT_VEC_BASE && v < EXT_VEC_BASE + EXT_GROUPS)
                pend[v] = ext_req[v-EXT_VEC_BASE];
            codes[2*v +: 2] = prio_q[v];
        end
    end

    // in halt only wake capable vectors compete; a higher non-waking
    // one simply waits for the next boundary
    always_comb begin
        elig = pend;
        if (state_q == HALT) elig = pend & WAKE_MASK[NUM_VEC-1:0];
        if (!nested_q && depth_q != 4'h0) elig = '0;
    end

    assign cur_level = code_to_level(cur_code);

    prio_arbiter #(.N(NUM_VEC)) u_arb (
        .req(elig),
        .codes(codes),
        .cur_level(cur_level),
        .found(found),
        .idx(win_idx),
        .win_level(win_level)
    );

    // ---- entry decision ----
    // an instruction that rewrites the mask defers trap and maskable entry by one cycle so
    // the stacked condition code never races the hardware load
    assign cc_op = rim_exec | sim_exec | halt_exec | wfi_exec
                 | irq_return_instr_exec | popcc_exec;
    assign take_reset = reset_pend_q & ~irq_take_q;
    assign take_trap = trap_pend_q & ~reset_pend_q & ~cc_op
                     & ~irq_take_q;
    assign take_mask = found & ~reset_pend_q & ~trap_pend_q & ~cc_op
                     & ~irq_take_q
                     & (instr_done | state_q == HALT);

    always_ff @(posedge clock) begin
        if (rst) reset_pend_q <= 1'b1;
        else if (take_reset) reset_pend_q <= 1'b0;
    end

    always_ff @(posedge clock) begin
        if (rst) trap_pend_q <= 1'b0;
        else if (trap_exec) trap_pend_q <= 1'b1;
        else if (take_trap) trap_pend_q <= 1'b0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_take_q <= 1'b0;
            irq_vec_q <= 4'h0;
            irq_stack_q <= 1'b0;
        end else begin
            irq_take_q <= take_reset | take_trap | take_mask;
            irq_stack_q <= ~take_reset;
            if (take_reset) irq_vec_q <= VEC_RESET;
            else if (take_trap) irq_vec_q <= VEC_TRAP;
            else if (take_mask) irq_vec_q <= win_idx;
        end
    end

    // handler depth tells concurrent mode that a handler is running
    always_ff @(posedge clock) begin
        if (rst) depth_q <= 4'h0;
        else if ((take_trap | take_mask) && !irq_return_instr_exec && depth_q != 4'hF)
            depth_q <= depth_q + 4'h1;
        else if (irq_return_instr_exec && !(take_trap | take_mask) && depth_q != 4'h0)
            depth_q <= depth_q - 4'h1;
    end

    // ---- current priority bits ----
    always_ff @(posedge clock) begin
        if (rst) begin
            {prio_bit_high_q, prio_bit_low_q} <= CC_PRIO_RST;
        end else if (take_reset | take_trap) begin
            {prio_bit_high_q, prio_bit_low_q} <= CODE_L3;
        end else if (take_mask) begin
            {prio_bit_high_q, prio_bit_low_q} <= prio_q[win_idx];
        end else if (irq_return_instr_exec) begin
            {prio_bit_high_q, prio_bit_low_q} <= irq_return_instr_code;
        end else if (popcc_exec) begin
            {prio_bit_high_q, prio_bit_low_q} <= popcc_code;
        end else if (sim_exec) begin
            {prio_bit_high_q, prio_bit_low_q} <= CODE_L3;
        end else if (rim_exec | halt_exec | wfi_exec) begin
            {prio_bit_high_q, prio_bit_low_q} <= CODE_L0;
        end
    end

    // ---- halt ----
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= RUN;
            halted_q <= 1'b0;
        end else begin
            case (state_q)
                RUN: if (halt_exec) begin
                    state_q <= HALT;
                    halted_q <= 1'b1;
                end
                HALT: if (take_mask | take_trap | trap_exec) begin
                    state_q <= RUN;
                    halted_q <= 1'b0;
                end
                default: begin
                    state_q <= RUN;
                    halted_q <= 1'b0;
                end
            endcase
        end
    end

    // ---- assertions ----
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_bus_req;
        (read | write) && waitrequest_q;
    endsequence
    sequence s_bus_ans;
        !waitrequest_q ##1 waitrequest_q;
    endsequence
    property p_bus_answer;
        s_bus_req |=> s_bus_ans;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not after one wait cycle");

    property p_reset_first;
        $fell(reset_pend_q) |-> irq_take_q && irq_vec_q == VEC_RESET
            && !irq_stack_q;
    endproperty
    a_reset_first: assert property (p_reset_first)
        else $error("reset entry missing or stacked");

    property p_nmi_level3;
        irq_take_q && irq_vec_q >= VEC_TRAP |->
            {prio_bit_high_q, prio_bit_low_q} == CODE_L3;
    endproperty
    a_nmi_level3: assert property (p_nmi_level3)
        else $error("non-maskable entry did not set level 3");

    sequence s_trap_seen;
        trap_exec && !reset_pend_q && !cc_op && !irq_take_q
            && !take_mask && !take_trap;
    endsequence
    property p_trap_taken;
        s_trap_seen ##1 !cc_op |=> irq_take_q && irq_vec_q == VEC_TRAP;
    endproperty
    a_trap_taken: assert property (p_trap_taken)
        else $error("trap not entered");

    property p_mask_level;
        irq_take_q && irq_vec_q < 4'(NUM_VEC) |->
            $past(win_level) > $past(cur_level)
            && cur_level == $past(win_level);
    endproperty
    a_mask_level: assert property (p_mask_level)
        else $error("maskable entry at or below current level");

    property p_halt_wake;
        $fell(halted_q) && !$past(trap_exec) |->
            irq_take_q && (WAKE_MASK[irq_vec_q] || irq_vec_q == VEC_TRAP);
    endproperty
    a_halt_wake: assert property (p_halt_wake)
        else $error("halt left through a non-waking vector");

    property p_concurrent;
        !$past(nested_q) && $past(depth_q) != 4'h0 && irq_take_q |->
            irq_vec_q >= VEC_TRAP;
    endproperty
    a_concurrent: assert property (p_concurrent)
        else $error("handler preempted in concurrent mode");

    property p_rim;
        rim_exec && !(take_reset | take_trap | take_mask) && !irq_return_instr_exec
            && !popcc_exec && !sim_exec |=>
            {prio_bit_high_q, prio_bit_low_q} == CODE_L0;
    endproperty
    a_rim: assert property (p_rim)
        else $error("enable instruction did not load level 0");

    property p_pair_keep;
        bus_wr && byteenable[0] && address == ADDR_VPRIO0
            && writedata[5:4] == CODE_L0 |=> prio_q[2] == $past(prio_q[2]);
    endproperty
    a_pair_keep: assert property (p_pair_keep)
        else $error("level 0 write changed a priority pair");

    property p_ro_pairs;
        prio_q[RO_PAIR_FIRST] == CODE_L3 && prio_q[NUM_PAIRS-1] == CODE_L3;
    endproperty
    a_ro_pairs: assert property (p_ro_pairs)
        else $error("read-only priority bits changed");
endmodule

// ### bench/core_model.sv
// cpu core stand-in: gives instruction boundaries and records entries
`timescale 1ns/1ps
module core_model (
    input wire logic clock, // system clock
    input wire logic irq_take_q, // entry pulse
    input wire logic [3:0] irq_vec_q, // vector entered
    input wire logic irq_stack_q, // stacking request
    output logic instr_done, // instruction boundary
    output logic [3:0] last_vec, // last vector entered
    output logic last_stack, // stacking flag of last entry
    output int n_take // entries seen
);
    // one-cycle instructions: every edge is a boundary
    assign instr_done = 1'b1;
    initial n_take = 0;
    always @(posedge clock) begin
        if (irq_take_q === 1'b1) begin
            last_vec <= irq_vec_q;
            last_stack <= irq_stack_q;
            n_take <= n_take + 1;
        end
    end
endmodule

// ### bench/nested_interrupt_priority_tb_top.sv
// register and entry-order tests of the nested interrupt controller
`timescale 1ns/1ps
module nested_interrupt_priority_tb_top;
    import nip_pkg::*;
    logic clock, rst, read, write, instr_done, last_stack, waitrequest_q;
    logic irq_take_q, irq_stack_q, prio_bit_high_q, prio_bit_low_q, halted_q;
    logic [5:0] address;
    logic [31:0] writedata, readdata_q, rdv;
    logic [3:0] irq_vec_q, last_vec;
    logic [12:0] periph_flag, periph_en, periph_clr;
    logic [4:0] ops;
    logic [11:0] ext_pin;
    logic [1:0] irq_return_instr_code;
    int n_take, err_total, n_compared;
    logic trap_exec, rim_exec, sim_exec, halt_exec, irq_return_instr_exec;
    assign {irq_return_instr_exec, halt_exec, sim_exec, rim_exec, trap_exec} = ops;
    nested_interrupt_priority nested_interrupt_priority_i (.clock, .rst,
        .address, .read, .write, .byteenable(4'hF), .writedata, .readdata_q,
        .waitrequest_q, .ext_pin, .periph_flag, .periph_en,
        .periph_clr, .instr_done, .trap_exec, .rim_exec, .sim_exec,
        .halt_exec, .wfi_exec(1'b0), .irq_return_instr_exec, .irq_return_instr_code,
        .popcc_exec(1'b0), .popcc_code(2'h3), .irq_take_q, .irq_vec_q,
        .irq_stack_q, .prio_bit_high_q, .prio_bit_low_q, .halted_q);
    core_model core_model_i (.clock, .irq_take_q, .irq_vec_q, .irq_stack_q,
        .instr_done, .last_vec, .last_stack, .n_take);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !we;
        write <= we;
        // hold the request until waitrequest is sampled low
        do begin
            @(posedge clock);
            t++;
        end while (waitrequest_q !== 1'b0 && t < 20);
        chk("waitrequest", 32'h0, {31'h0, waitrequest_q});
        rdv = readdata_q;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("readdata", e, rdv);
    endtask
    task automatic op(input int i); // 0 trap 1 rim 2 sim 3 halt 4 irq_return_instr
        @(posedge clock);
        ops[i] <= 1'b1;
        @(posedge clock);
        ops[i] <= 1'b0;
        #1;
    endtask
    task automatic take(input logic [3:0] v, input logic [1:0] c);
        int n0, t;
        n0 = n_take;
        t = 0;
        while (n_take == n0 && t < 50) begin
            @(posedge clock);
            #1;
            t++;
        end
        chk("entry", n0 + 1, n_take);
        chk("vector", {28'h0, v}, {28'h0, last_vec});
        chk("prio", {30'h0, c}, {30'h0, prio_bit_high_q, prio_bit_low_q});
    endtask
    task automatic serve(input int v); // flag clear sequence
        @(posedge clock);
        periph_flag[v] <= 1'b0;
        periph_clr[v] <= 1'b1;
        @(posedge clock);
        periph_clr[v] <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        print_verdict();
    end
    initial begin
        {rst, read, write, ops, periph_flag, periph_clr} = '0;
        rst = 1'b1;
        address = 6'h0;
        writedata = 32'h0;
        ext_pin = 12'hFFF;
        irq_return_instr_code = CODE_L0;
        periph_en = 13'h1BFF; // vector 10 left disabled
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        take(VEC_RESET, CODE_L3);
        chk("stack", 0, {31'h0, last_stack});
        rdchk(ADDR_VPRIO0, 32'hFF);
        bus(1'b1, ADDR_VPRIO0, 32'hCF);
        bus(1'b1, ADDR_VPRIO0, 32'h64);
        rdchk(ADDR_VPRIO0, 32'h44);
        bus(1'b1, ADDR_VPRIO3, 32'h00);
        rdchk(ADDR_VPRIO3, 32'hF0);
        rdchk(6'h3C, 32'h0);
        bus(1'b1, ADDR_VPRIO1, 32'h7F); // vector 7 at level 1
        op(1);
        chk("prio", CODE_L0, {prio_bit_high_q, prio_bit_low_q});
        @(posedge clock);
        periph_flag <= 13'h07E0; // vectors 5 to 10 at once
        take(4'h5, CODE_L3);
        serve(5);
        serve(9);
        op(4);
        take(4'h6, CODE_L3);
        serve(6);
        op(4);
        take(4'h8, CODE_L3);
        serve(8);
        op(4);
        take(4'h7, CODE_L1);
        serve(7);
        op(4);
        chk("prio", CODE_L0, {prio_bit_high_q, prio_bit_low_q});
        repeat (5) @(posedge clock);
        rdchk(ADDR_PEND, 32'h0);
        chk("entries", 5, n_take);
        op(2);
        chk("prio", CODE_L3, {prio_bit_high_q, prio_bit_low_q});
        op(0);
        take(VEC_TRAP, CODE_L3);
        chk("stack", 1, {31'h0, last_stack});
        op(3);
        chk("halted", 1, {31'h0, halted_q});
        op(0);
        take(VEC_TRAP, CODE_L3);
        chk("halted", 0, {31'h0, halted_q});
        bus(1'b1, ADDR_PINSEL, 32'h3); // group 0, pins 0 and 1
        bus(1'b1, ADDR_SENSE, 32'h2); // group 0 on falling edges
        op(3);
        @(posedge clock);
        ext_pin[1:0] <= 2'h0;
        take(4'h2, CODE_L2);
        chk("halted", 0, {31'h0, halted_q});
        rdchk(ADDR_PEND, 32'h0);
        bus(1'b1, ADDR_MODE, 32'h0); // concurrent mode
        periph_flag[5] <= 1'b1;
        repeat (5) @(posedge clock);
        op(4);
        op(4);
        chk("entries", 8, n_take);
        op(4);
        take(4'h5, CODE_L3);
        print_verdict();
    end
endmodule
